// *** pms_pkg.sv ***
`default_nettype none
package pms_pkg;
  // ***************************************************
  // Timing
  // ***************************************************
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned MDC_MAX_HZ   = 2_500_000;
  // Least half period of the management clock, rounded up
  localparam int unsigned MDC_MIN_HALF = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);

  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [7:0]  OFS_SETUP     = 8'h00;
  localparam logic [7:0]  OFS_CTRL      = 8'h04;
  localparam logic [7:0]  OFS_WDATA     = 8'h08;
  localparam logic [7:0]  OFS_RDATA     = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h14;
  localparam int          DIV_W         = 6;
  localparam int          SETUP_EN_BIT  = 6;
  localparam int          ADR_W         = 5;
  localparam int          CTRL_PHY_LSB  = 24;
  localparam int          CTRL_REG_LSB  = 16;
  localparam int          CTRL_OP_LSB   = 14;
  localparam int          CTRL_INIT_BIT = 11;
  localparam int          CTRL_DONE_BIT = 7;
  localparam logic [DIV_W-1:0] DIV_RST  = 6'h00;
  localparam logic [ADR_W-1:0] ADR_RST  = 5'h00;

  // ***************************************************
  // Frame format
  // ***************************************************
  localparam logic [1:0]  OP_WRITE      = 2'b01;
  localparam logic [1:0]  OP_READ       = 2'b10;
  localparam logic [31:0] PREAMBLE      = 32'hFFFFFFFF;
  localparam logic [1:0]  FRAME_START   = 2'b01;
  localparam logic [1:0]  TA_WRITE      = 2'b10;
  localparam logic [5:0]  TA_BIT        = 6'h2E;
  localparam logic [5:0]  DATA_BIT      = 6'h30;
  localparam logic [5:0]  FRAME_LAST    = 6'h3F;

  typedef enum logic [2:0] {
    PMS_IDLE  = 3'b001,
    PMS_WAIT  = 3'b010,
    PMS_SHIFT = 3'b100
  } pms_state_t;
endpackage : pms_pkg
`default_nettype wire

// *** pms_xfer_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface pms_xfer_if;
  logic        start;
  logic [1:0]  op;
  logic [4:0]  phy;
  logic [4:0]  phy_register_select;
  logic [15:0] wdata;
  logic        busy;
  logic        done;
  logic        was_read;
  logic [15:0] rdata;

  modport ctrl (output start, op, phy, phy_register_select, wdata, input busy, done, was_read, rdata);
  modport eng  (input start, op, phy, phy_register_select, wdata, output busy, done, was_read, rdata);
endinterface : pms_xfer_if
`default_nettype wire

// *** pms_mdc_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module pms_mdc_gen
  import pms_pkg::*;
#(
  parameter int DW = pms_pkg::DIV_W
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          enable,
  input  wire logic [DW-1:0] divisor,
  output logic               mdc,
  output logic               mdc_rise,
  output logic               mdc_fall
);
  logic [DW:0] cnt_r, cnt_nxt, half;
  logic        mdc_r, mdc_nxt, rise_r, rise_nxt, fall_r, fall_nxt;

  always_comb begin
    // Clamp keeps the clock legal even for a divisor of zero
    half = {1'b0, divisor} + {{DW{1'b0}}, 1'b1};
    if (half < (DW+1)'(MDC_MIN_HALF)) begin
      half = (DW+1)'(MDC_MIN_HALF);
    end
    cnt_nxt  = cnt_r + {{DW{1'b0}}, 1'b1};
    mdc_nxt  = mdc_r;
    rise_nxt = 1'b0;
    fall_nxt = 1'b0;
    // A running high phase is finished first, so disabling leaves no runt pulse
    if (!enable && !mdc_r) begin
      cnt_nxt = '0;
      mdc_nxt = 1'b0;
    end else if (cnt_r >= half - {{DW{1'b0}}, 1'b1}) begin
      cnt_nxt  = '0;
      mdc_nxt  = ~mdc_r;
      rise_nxt = ~mdc_r;
      fall_nxt = mdc_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= '0;
      mdc_r  <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      mdc_r  <= mdc_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign mdc      = mdc_r;
  assign mdc_rise = rise_r;
  assign mdc_fall = fall_r;
endmodule : pms_mdc_gen
`default_nettype wire

// *** pms_mdio_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
module pms_mdio_engine
  import pms_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic mdc_rise,
  input  wire logic mdc_fall,
  input  wire logic mdio_in,
  output logic      mdio_o,
  output logic      mdio_oe_n,
  pms_xfer_if.eng   x
);
  pms_state_t  state_r, state_nxt;
  logic [63:0] sh_r, sh_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic        rd_r, rd_nxt, out_r, out_nxt, oen_r, oen_nxt, done_r, done_nxt;
  logic [15:0] rdata_r, rdata_nxt;

  always_comb begin
    state_nxt = state_r;
    sh_nxt    = sh_r;
    cnt_nxt   = cnt_r;
    rd_nxt    = rd_r;
    out_nxt   = out_r;
    oen_nxt   = oen_r;
    done_nxt  = 1'b0;
    rdata_nxt = rdata_r;
    case (state_r)
      PMS_IDLE: begin
        if (x.start) begin
          // Fields are latched here so later control writes cannot disturb the frame
          sh_nxt    = {PREAMBLE, FRAME_START, x.op, x.phy, x.phy_register_select, TA_WRITE, x.wdata};
          rd_nxt    = (x.op == OP_READ);
          state_nxt = PMS_WAIT;
        end
      end
      PMS_WAIT: begin
        // Launch on a falling edge so the first bit is settled before the PHY samples
        if (mdc_fall) begin
          out_nxt   = sh_r[63];
          oen_nxt   = 1'b0;
          cnt_nxt   = '0;
          state_nxt = PMS_SHIFT;
        end
      end
      PMS_SHIFT: begin
        if (mdc_rise && rd_r && cnt_r >= DATA_BIT) begin
          rdata_nxt = {rdata_r[14:0], mdio_in};
        end
        if (mdc_fall) begin
          if (cnt_r == FRAME_LAST) begin
            oen_nxt   = 1'b1;
            out_nxt   = 1'b1;
            done_nxt  = 1'b1;
            state_nxt = PMS_IDLE;
          end else begin
            cnt_nxt = cnt_r + 6'h01;
            sh_nxt  = {sh_r[62:0], 1'b0};
            out_nxt = sh_r[62];
            oen_nxt = rd_r && (cnt_r + 6'h01 >= TA_BIT);
          end
        end
      end
      default: state_nxt = PMS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= PMS_IDLE;
      sh_r    <= '0;
      cnt_r   <= '0;
      rd_r    <= 1'b0;
      out_r   <= 1'b1;
      oen_r   <= 1'b1;
      done_r  <= 1'b0;
      rdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      sh_r    <= sh_nxt;
      cnt_r   <= cnt_nxt;
      rd_r    <= rd_nxt;
      out_r   <= out_nxt;
      oen_r   <= oen_nxt;
      done_r  <= done_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign x.busy     = (state_r != PMS_IDLE);
  assign x.done     = done_r;
  assign x.was_read = rd_r;
  assign x.rdata    = rdata_r;
  assign mdio_o     = out_r;
  assign mdio_oe_n  = oen_r;
endmodule : pms_mdio_engine
`default_nettype wire

// *** pms_phy_mgmt_master.sv ***
//
// Functional notes
// - Five-bit addresses; zero is an ordinary address, not broadcast
// - Management clock never above 2.5 MHz
// - Two-wire link: clock out, shared data
// - Initiate bit starts transfer with held fields
// - Opcode 01 writes, 10 reads
// - Read result lands in read data register
// - Done flag bit 7 set on completion
// - Completion seen by polling or interrupt
// - Host bus never stalled during transfer
// - Control rewrite captured, start deferred
// - Read data valid when first transfer ends
// - On-chip PHY answers only its address
//
`timescale 1ns/1ps
`default_nettype none
module pms_phy_mgmt_master
  import pms_pkg::*;
#(
  parameter logic [pms_pkg::ADR_W-1:0] internal_phy_address_param = 5'h01
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_n,
  input  wire logic        int_phy_mdio_i,
  output logic             int_phy_hit,
  output logic             irq
);
  import pms_pkg::*;

  // ***************************************************
  // Declarations
  // ***************************************************
  pms_xfer_if x ();

  logic [DIV_W-1:0] div_r, div_nxt;
  logic             en_r, en_nxt;
  logic [ADR_W-1:0] phy_r, phy_nxt, phy_register_select_r, phy_register_select_nxt;
  logic [1:0]       op_r, op_nxt;
  logic             init_r, init_nxt, pend_r, pend_nxt, start_r, start_nxt;
  logic             hit_r, hit_nxt, ist_r, ist_nxt, imask_r, imask_nxt;
  logic [15:0]      wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [31:0]      prdata_r, prdata_nxt, ctrl_val;
  logic             sync1_r, sync2_r;
  logic             mdc_rise, mdc_fall, eng_in, ready;
  logic             setup, wr_acc, rd_acc, wr_ctrl, mapped;

  // ***************************************************
  // APB decode
  // ***************************************************
  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign wr_ctrl = wr_acc && (paddr == OFS_CTRL);
  assign mapped  = (paddr == OFS_SETUP) || (paddr == OFS_CTRL) || (paddr == OFS_WDATA) ||
                   (paddr == OFS_RDATA) || (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK);

  // Zero wait states: read data is fetched in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_r;

  // ***************************************************
  // Status view
  // ***************************************************
  assign ready = ~x.busy & ~pend_r & ~start_r;

  always_comb begin
    ctrl_val                                 = 32'h00000000;
    ctrl_val[CTRL_PHY_LSB +: ADR_W]          = phy_r;
    ctrl_val[CTRL_REG_LSB +: ADR_W]          = phy_register_select_r;
    ctrl_val[CTRL_OP_LSB +: 2]               = op_r;
    ctrl_val[CTRL_INIT_BIT]                  = init_r;
    ctrl_val[CTRL_DONE_BIT]                  = ready;
  end

  // ***************************************************
  // Register file and request queue
  // ***************************************************
  always_comb begin
    div_nxt    = div_r;
    en_nxt     = en_r;
    phy_nxt    = phy_r;
    phy_register_select_nxt  = phy_register_select_r;
    op_nxt     = op_r;
    init_nxt   = init_r;
    pend_nxt   = pend_r;
    wdata_nxt  = wdata_r;
    rdata_nxt  = rdata_r;
    imask_nxt  = imask_r;
    ist_nxt    = ist_r;
    prdata_nxt = prdata_r;
    hit_nxt    = hit_r;
    // Not started in a cycle that rewrites control, so the held fields stay coherent
    start_nxt  = pend_r & ~x.busy & ~start_r & en_r & ~wr_ctrl;
    if (start_nxt) begin
      pend_nxt = 1'b0;
      hit_nxt  = (phy_r == internal_phy_address_param);
    end
    if (wr_acc) begin
      case (paddr)
        OFS_SETUP: begin
          div_nxt = pwdata[DIV_W-1:0];
          en_nxt  = pwdata[SETUP_EN_BIT];
        end
        OFS_CTRL: begin
          // Captured at once; a running transfer keeps its own latched copy
          phy_nxt   = pwdata[CTRL_PHY_LSB +: ADR_W];
          phy_register_select_nxt = pwdata[CTRL_REG_LSB +: ADR_W];
          op_nxt    = pwdata[CTRL_OP_LSB +: 2];
          init_nxt  = pwdata[CTRL_INIT_BIT];
          if (pwdata[CTRL_INIT_BIT]) begin
            pend_nxt = 1'b1;
          end
        end
        OFS_WDATA:    wdata_nxt = pwdata[15:0];
        OFS_IRQ_MASK: imask_nxt = pwdata[0];
        default: ;
      endcase
    end
    if (x.done && x.was_read) begin
      rdata_nxt = x.rdata;
    end
    // Only a status bit the reader actually saw is cleared
    if (rd_acc && paddr == OFS_IRQ_STAT && prdata_r[0]) begin
      ist_nxt = 1'b0;
    end
    if (x.done) begin
      ist_nxt = 1'b1;
    end
    if (setup) begin
      case (paddr)
        OFS_SETUP:    prdata_nxt = {25'h0000000, en_r, div_r};
        OFS_CTRL:     prdata_nxt = ctrl_val;
        OFS_WDATA:    prdata_nxt = {16'h0000, wdata_r};
        OFS_RDATA:    prdata_nxt = {16'h0000, rdata_r};
        OFS_IRQ_STAT: prdata_nxt = {31'h00000000, ist_r};
        OFS_IRQ_MASK: prdata_nxt = {31'h00000000, imask_r};
        default:      prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_r    <= DIV_RST;
      en_r     <= 1'b0;
      phy_r    <= ADR_RST;
      phy_register_select_r  <= ADR_RST;
      op_r     <= 2'b00;
      init_r   <= 1'b0;
      pend_r   <= 1'b0;
      start_r  <= 1'b0;
      hit_r    <= 1'b0;
      wdata_r  <= 16'h0000;
      rdata_r  <= 16'h0000;
      imask_r  <= 1'b0;
      ist_r    <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      div_r    <= div_nxt;
      en_r     <= en_nxt;
      phy_r    <= phy_nxt;
      phy_register_select_r  <= phy_register_select_nxt;
      op_r     <= op_nxt;
      init_r   <= init_nxt;
      pend_r   <= pend_nxt;
      start_r  <= start_nxt;
      hit_r    <= hit_nxt;
      wdata_r  <= wdata_nxt;
      rdata_r  <= rdata_nxt;
      imask_r  <= imask_nxt;
      ist_r    <= ist_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign irq = ist_r & imask_r;

  // ***************************************************
  // Link side
  // ***************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= mdio_i;
      sync2_r <= sync1_r;
    end
  end

  // Internal PHY sits on the same clock, so it skips the synchroniser
  assign eng_in      = hit_r ? int_phy_mdio_i : sync2_r;
  assign int_phy_hit = hit_r & x.busy;

  assign x.start = start_r;
  assign x.op    = op_r;
  assign x.phy   = phy_r;
  assign x.phy_register_select = phy_register_select_r;
  assign x.wdata = wdata_r;

  pms_mdc_gen #(
    .DW       (DIV_W)
  ) u_mdc (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .enable   (en_r),
    .divisor  (div_r),
    .mdc      (mdc),
    .mdc_rise (mdc_rise),
    .mdc_fall (mdc_fall)
  );

  pms_mdio_engine u_eng (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .mdc_rise  (mdc_rise),
    .mdc_fall  (mdc_fall),
    .mdio_in   (eng_in),
    .mdio_o    (mdio_o),
    .mdio_oe_n (mdio_oe_n),
    .x         (x)
  );

  // ***************************************************
  // Assertions
  // ***************************************************
  logic [7:0] mdc_age_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mdc_age_r <= 8'h00;
    end else if (mdc_rise || mdc_fall) begin
      mdc_age_r <= 8'h00;
    end else if (mdc_age_r != 8'hFF) begin
      mdc_age_r <= mdc_age_r + 8'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_no_stall;
    psel && penable |-> pready;
  endproperty
  a_no_stall: assert property (p_no_stall) else $error("bus stalled");

  property p_mdc_rate;
    $changed(mdc) && $past(mdc_age_r) != 8'h00 |-> $past(mdc_age_r) >= 8'(MDC_MIN_HALF - 2);
  endproperty
  a_mdc_rate: assert property (p_mdc_rate) else $error("mdc too fast");

  property p_mdc_idle;
    !en_r && !mdc |=> !mdc;
  endproperty
  a_mdc_idle: assert property (p_mdc_idle) else $error("mdc runs while disabled");

  property p_defer;
    x.busy && wr_ctrl && pwdata[CTRL_INIT_BIT] |=> pend_r && !ready;
  endproperty
  a_defer: assert property (p_defer) else $error("queued request lost");

  property p_start;
    start_r |=> x.busy ##[1:300] (mdio_oe_n == 1'b0);
  endproperty
  a_start: assert property (p_start) else $error("start did not launch frame");

  property p_done_flag;
    x.done && !pend_r && !wr_ctrl |=> prdata_nxt[CTRL_DONE_BIT] || !setup || paddr != OFS_CTRL;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag not shown");

  property p_rdata;
    x.done && x.was_read |=> rdata_r == $past(x.rdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not stored");

  property p_irq;
    x.done && imask_r && !(wr_acc && paddr == OFS_IRQ_MASK) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_idle_release;
    !x.busy |-> mdio_oe_n;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("line driven while idle");

  c_write: cover property (x.done && !x.was_read);
  c_read: cover property (x.done && x.was_read);
  c_queued: cover property (x.busy && wr_ctrl && pwdata[CTRL_INIT_BIT]);
  c_irq: cover property (irq);
endmodule : pms_phy_mgmt_master
`default_nettype wire

// *** pms_phy_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pms_phy_model #(
  parameter logic [4:0]  ADDR = 5'h1F,
  parameter logic [15:0] BASE = 16'h5A00
) (
  input  wire logic mdc,
  input  wire logic mdio,
  output logic      drv_o,
  output logic      drv_en
);
  logic [15:0] regs [32];
  logic [15:0] sh;
  logic [1:0]  op;
  logic [1:0]  ta;
  logic [4:0]  phy;
  logic [4:0]  ra;
  logic        st;
  logic        rdx;
  int          ones;
  int          pre;
  int          cnt;
  int          frames;

  initial begin
    for (int i = 0; i < 32; i++) regs[i] = BASE ^ 16'(i);
    sh = 16'h0000;
    drv_o = 1'b1;
    drv_en = 1'b0;
    rdx = 1'b0;
    ones = 0;
    pre = 0;
    cnt = 0;
    frames = 0;
  end

  // ***************************************************
  // Frame capture, sampled on rising clock
  // ***************************************************
  always @(posedge mdc) begin
    if (cnt == 0) begin
      if (mdio === 1'b1) ones++;
      else if (ones >= 32) begin
        cnt = 1;
        pre = ones;
      end else ones = 0;
    end else begin
      sh = {sh[14:0], mdio};
      cnt++;
      if (cnt == 14) begin
        {st, op, phy, ra} = sh[12:0];
        rdx = (op == 2'b10) && (phy == ADDR);
      end
      if (cnt == 16) ta = sh[1:0];
      if (cnt == 32) begin
        frames++;
        if (op == 2'b01 && phy == ADDR) regs[ra] = sh;
        cnt = 0;
        ones = 0;
        rdx = 1'b0;
      end
    end
  end

  // ***************************************************
  // Read answer; drives the turnaround zero and the data, released otherwise
  // ***************************************************
  always @(negedge mdc) begin
    if (rdx && cnt >= 15 && cnt <= 31) begin
      drv_en = 1'b1;
      drv_o = (cnt == 15) ? 1'b0 : regs[ra][31-cnt];
    end else begin
      drv_en = 1'b0;
    end
  end
endmodule : pms_phy_model
`default_nettype wire

// *** pms_phy_mgmt_master_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module pms_phy_mgmt_master_test;
  import pms_pkg::*;
  localparam logic [15:0] EXT_BASE = 16'h5A00;
  localparam logic [15:0] INT_BASE = 16'hC300;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mdc;
  logic        mdio_o;
  logic        mdio_oe_n;
  logic        int_phy_mdio_i;
  logic        int_phy_hit;
  logic        irq;
  logic        ext_o;
  logic        ext_en;
  logic        int_o;
  logic        int_en;
  logic        serr;
  logic [31:0] q;
  logic [31:0] p;
  int          failures = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;
  tri1         mdio_line;

  // Shared line with pull-up; on-chip path inverts when idle
  assign mdio_line = mdio_oe_n ? 1'bz : mdio_o;
  assign mdio_line = ext_en ? ext_o : 1'bz;
  assign int_phy_mdio_i = int_en ? int_o : ~int_o;

  always #10 ref_clk = ~ref_clk;

  pms_phy_mgmt_master #(.internal_phy_address_param(5'h01)) i_pms_phy_mgmt_master (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mdc(mdc), .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n),
    .int_phy_mdio_i(int_phy_mdio_i), .int_phy_hit(int_phy_hit), .irq(irq));
  pms_phy_model #(.ADDR(5'h1F), .BASE(EXT_BASE)) i_phy_ext (
    .mdc(mdc), .mdio(mdio_line), .drv_o(ext_o), .drv_en(ext_en));
  pms_phy_model #(.ADDR(5'h01), .BASE(INT_BASE)) i_phy_int (
    .mdc(mdc), .mdio(mdio_line), .drv_o(int_o), .drv_en(int_en));

  // ***************************************************
  // Tasks
  // ***************************************************
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) failures++;
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd

  task automatic wait_done;
    n = 0;
    do begin
      apb(1'b0, OFS_CTRL, 32'h0);
      n++;
    end while (q[CTRL_DONE_BIT] !== 1'b1 && n < 3000);
    if (n == 3000) failures++;
    repeat (2) @(posedge ref_clk);
  endtask : wait_done

  task automatic mdc_period;
    time t0;
    @(posedge mdc);
    t0 = $time;
    @(posedge mdc);
    p = 32'(($time - t0) / 20);
  endtask : mdc_period

  task automatic idle_mdc;
    n = 0;
    // A high phase already running may finish before the clock rests
    repeat (MDC_MIN_HALF + 2) @(posedge ref_clk);
    repeat (300) begin
      @(negedge ref_clk);
      if (mdc !== 1'b0) n++;
    end
    chk(32'(n), 32'h0);
  endtask : idle_mdc

  function automatic logic [31:0] cw(input logic [4:0] ph, input logic [4:0] rg,
                                     input logic [1:0] o);
    return {3'h0, ph, 3'h0, rg, o, 2'h0, 1'b1, 11'h000};
  endfunction : cw

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      test_done();
    end
  end

  // ***************************************************
  // Sequence
  // ***************************************************
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_SETUP, 32'h0);
    rd(OFS_CTRL, 32'h80);
    rd(OFS_RDATA, 32'h0);
    rd(OFS_IRQ_STAT, 32'h0);
    rd(8'h18, 32'h0);
    chk(32'(serr), 32'h1);
    idle_mdc();
    apb(1'b1, OFS_SETUP, 32'h40);
    mdc_period();
    chk(p, 32'h14);
    apb(1'b1, OFS_SETUP, 32'h54);
    mdc_period();
    mdc_period();
    chk(p, 32'h2A);
    apb(1'b1, OFS_SETUP, 32'h40);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    apb(1'b1, OFS_CTRL, cw(5'h1F, 5'h1F, OP_WRITE) & 32'hFFFFF7FF);
    repeat (300) @(posedge ref_clk);
    chk(32'(i_phy_ext.frames), 32'h0);
    apb(1'b1, OFS_WDATA, 32'hABCD);
    apb(1'b1, OFS_CTRL, cw(5'h1F, 5'h1F, OP_WRITE));
    rd(OFS_SETUP, 32'h40);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(32'(q[CTRL_DONE_BIT]), 32'h0);
    wait_done();
    chk(32'(irq), 32'h1);
    chk(32'(i_phy_ext.op), 32'h1);
    chk(32'({i_phy_ext.st, i_phy_ext.phy, i_phy_ext.ra}), 32'h7FF);
    chk(32'(i_phy_ext.ta), 32'h2);
    chk(32'(i_phy_ext.regs[31]), 32'hABCD);
    chk(32'(i_phy_ext.pre >= 32), 32'h1);
    rd(OFS_IRQ_STAT, 32'h1);
    rd(OFS_IRQ_STAT, 32'h0);
    chk(32'(irq), 32'h0);
    // Read, then a write queued behind it
    apb(1'b1, OFS_CTRL, cw(5'h1F, 5'h03, OP_READ));
    repeat (4) @(posedge ref_clk);
    apb(1'b1, OFS_CTRL, cw(5'h1F, 5'h04, OP_WRITE));
    n = 0;
    while (i_phy_ext.frames != 2 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (25) @(posedge ref_clk);
    rd(OFS_RDATA, 32'(EXT_BASE ^ 16'h0003));
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(32'(q[CTRL_DONE_BIT]), 32'h0);
    wait_done();
    chk(32'(i_phy_ext.regs[4]), 32'hABCD);
    chk(32'(i_phy_ext.frames), 32'h3);
    // On-chip device, interrupt masked
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    apb(1'b1, OFS_CTRL, cw(5'h01, 5'h02, OP_READ));
    n = 0;
    while (int_phy_hit !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk(32'(int_phy_hit), 32'h1);
    wait_done();
    rd(OFS_RDATA, 32'(INT_BASE ^ 16'h0002));
    chk(32'(int_phy_hit), 32'h0);
    chk(32'(irq), 32'h0);
    rd(OFS_IRQ_STAT, 32'h1);
    // Request while disabled waits for enable
    apb(1'b1, OFS_SETUP, 32'h0);
    apb(1'b1, OFS_CTRL, cw(5'h1F, 5'h05, OP_READ));
    idle_mdc();
    apb(1'b1, OFS_SETUP, 32'h40);
    wait_done();
    rd(OFS_RDATA, 32'(EXT_BASE ^ 16'h0005));
    test_done();
  end
endmodule : pms_phy_mgmt_master_test
`default_nettype wire
